// *** rtl/scm_pkg.sv ***
// constants for the supply and clock monitor register bank
package scm_pkg;

    // register select codes on the command port
    typedef enum logic [1:0] {
        SEL_CLK_MON_ENABLES = 2'h0,
        SEL_LOW_FLAGS       = 2'h1,
        SEL_HIGH_FLAGS      = 2'h2,
        SEL_EXT_FLAGS       = 2'h3
    } scm_sel_t;

    localparam int REG_W = 8;

    // clock monitor enables field positions
    localparam int BOOST_CLK_CHECK_EN_BIT       = 6;
    localparam int SECOND_BUCK_CLK_CHECK_EN_BIT = 4;
    localparam int FIRST_BUCK_CLK_CHECK_EN_BIT  = 3;
    localparam int SOURCE_CLK_CHECK_EN_BIT      = 2;
    localparam int SYNC_INPUT_CLK_CHECK_EN_BIT  = 1;

    // undervoltage flag positions
    localparam int INPUT_SUPPLY_LOW_BIT = 6;
    localparam int INTERNAL_REG_LOW_BIT = 4;
    localparam int BOOST_LOW_BIT        = 3;
    localparam int SECOND_BUCK_LOW_BIT  = 1;
    localparam int FIRST_BUCK_LOW_BIT   = 0;

    // overvoltage flag positions
    localparam int IO_SUPPLY_HIGH_BIT    = 7;
    localparam int INPUT_SUPPLY_HIGH_BIT = 6;
    localparam int INTERNAL_REG_HIGH_BIT = 4;
    localparam int BOOST_HIGH_BIT        = 3;
    localparam int SECOND_BUCK_HIGH_BIT  = 1;
    localparam int FIRST_BUCK_HIGH_BIT   = 0;

    // external monitor flag positions
    localparam int EXT_TWO_HIGH_BIT = 5;
    localparam int EXT_TWO_LOW_BIT  = 4;
    localparam int EXT_ONE_HIGH_BIT = 1;
    localparam int EXT_ONE_LOW_BIT  = 0;

    // implemented-bit masks, reserved bits are zero
    localparam logic [REG_W-1:0] CLK_MON_MASK   = 8'h5E;
    localparam logic [REG_W-1:0] LOW_MASK       = 8'h5B;
    localparam logic [REG_W-1:0] HIGH_MASK      = 8'hDB;
    localparam logic [REG_W-1:0] EXT_MASK       = 8'h33;

    // reset values
    localparam logic [REG_W-1:0] CLK_MON_RESET  = 8'h5C;
    localparam logic [REG_W-1:0] FLAGS_RESET    = 8'h00;

endpackage : scm_pkg

// *** rtl/scm_regs.sv ***
// clock monitor enable register and clear-on-read voltage status registers
// Contract
// - bit 6 enables boost clock check, reset 1
// - bit 4 enables second buck check, reset 1
// - bit 3 enables first buck check, reset 1
// - bit 2 enables clock source check, reset 1
// - bit 1 enables sync input check, reset 0
// - enable encoding: 0 off, 1 on
// - status flags latch high until read
// - read clears flag only if condition gone
// - status zero at power-on, updated by read
// - low flags: input bit 6, internal 4
// - low flags: boost 3, second_buck 1, first_buck 0
// - high flags: io 7, input 6, internal 4
// - high flags: boost 3, second_buck 1, first_buck 0
// - input high flag mirrors off-state copy
// - ext flags: monitor two high 5, low 4
// - ext flags: monitor one high 1, low 0
// - external detection masked while monitor disabled
// - flag 1 means fault, 0 none
// - control writes accepted only when unlocked
// - control resets on power-on and RESET state
module scm_regs
    import scm_pkg::*;
(
    // clock and power-on reset
    input  wire logic             CLK_SYS,
    input  wire logic             RSTN,
    // device state
    input  wire logic             DEVICE_RESET_STATE,
    input  wire logic             CTRL_LOCK,
    // register command port
    input  wire logic             CMD_RD,
    input  wire logic             CMD_WR,
    input  wire logic [1:0]       CMD_SEL,
    input  wire logic [REG_W-1:0] CMD_WDATA,
    output logic      [REG_W-1:0] RD_DATA,
    output logic                  RD_VALID,
    output logic                  WR_ACCEPTED,
    output logic                  WR_REFUSED,
    // monitor conditions, one bit per flag position, and external monitor enables
    input  wire logic [REG_W-1:0] LOW_COND,
    input  wire logic [REG_W-1:0] HIGH_COND,
    input  wire logic [REG_W-1:0] EXT_COND,
    input  wire logic             EXT_ONE_ENABLED,
    input  wire logic             EXT_TWO_ENABLED,
    // clock monitor enables
    output logic                  BOOST_CLK_CHECK_EN,
    output logic                  SECOND_BUCK_CLK_CHECK_EN,
    output logic                  FIRST_BUCK_CLK_CHECK_EN,
    output logic                  SOURCE_CLK_CHECK_EN,
    output logic                  SYNC_INPUT_CLK_CHECK_EN,
    // mirrored input overvoltage flag
    output logic                  INPUT_SUPPLY_HIGH_FLAG
);

    logic [REG_W-1:0] clk_mon_ff;
    logic [REG_W-1:0] low_ff;
    logic [REG_W-1:0] high_ff;
    logic [REG_W-1:0] ext_ff;
    logic [REG_W-1:0] nxt_low;
    logic [REG_W-1:0] nxt_high;
    logic [REG_W-1:0] nxt_ext;
    logic [REG_W-1:0] ext_cond_masked;
    logic [REG_W-1:0] rd_mux;
    logic             low_clr;
    logic             high_clr;
    logic             ext_clr;
    logic             ctrl_wr_hit;
    logic [REG_W-1:0] rd_data_ff;
    logic             rd_valid_ff;
    logic             wr_acc_ff;
    logic             wr_ref_ff;
    // next values and decode
    logic [REG_W-1:0] nxt_clk_mon;
    logic [REG_W-1:0] nxt_rd_data;
    logic             nxt_rd_valid;
    logic             nxt_wr_acc;
    logic             nxt_wr_ref;
    logic             ctrl_wr_take;
    scm_sel_t         cmd_sel;
    // masked read views
    logic [REG_W-1:0] ctl_view;
    logic [REG_W-1:0] low_view;
    logic [REG_W-1:0] high_view;
    logic [REG_W-1:0] ext_view;

    // sticky flag: condition sets, read clears only a departed condition
    function automatic logic flag_next(input logic flag, input logic cond, input logic clr);
        if (cond)
        begin
            flag_next = 1'b1;
        end
        else if (clr)
        begin
            flag_next = 1'b0;
        end
        else
        begin
            flag_next = flag;
        end
    endfunction : flag_next

    function automatic logic [REG_W-1:0] sel_read(input logic [1:0] sel,
                                                  input logic [REG_W-1:0] ctl,
                                                  input logic [REG_W-1:0] lo,
                                                  input logic [REG_W-1:0] hi,
                                                  input logic [REG_W-1:0] ex);
        case (scm_sel_t'(sel))
            SEL_CLK_MON_ENABLES: sel_read = ctl;
            SEL_LOW_FLAGS:       sel_read = lo;
            SEL_HIGH_FLAGS:      sel_read = hi;
            SEL_EXT_FLAGS:       sel_read = ex;
            default:             sel_read = FLAGS_RESET;
        endcase
    endfunction : sel_read

    assign cmd_sel = scm_sel_t'(CMD_SEL);

    // clearing strobes; a read of a status register updates it
    always_comb
    begin
        low_clr  = 1'b0;
        high_clr = 1'b0;
        ext_clr  = 1'b0;
        if (CMD_RD)
        begin
            case (cmd_sel)
                SEL_LOW_FLAGS:  low_clr  = 1'b1;
                SEL_HIGH_FLAGS: high_clr = 1'b1;
                SEL_EXT_FLAGS:  ext_clr  = 1'b1;
                default:
                begin
                    low_clr = 1'b0;
                end
            endcase
        end
    end

    // external detection masked while its monitor is off
    always_comb
    begin
        ext_cond_masked = '0;
        if (EXT_ONE_ENABLED)
        begin
            ext_cond_masked[EXT_ONE_HIGH_BIT] = EXT_COND[EXT_ONE_HIGH_BIT];
            ext_cond_masked[EXT_ONE_LOW_BIT]  = EXT_COND[EXT_ONE_LOW_BIT];
        end
        if (EXT_TWO_ENABLED)
        begin
            ext_cond_masked[EXT_TWO_HIGH_BIT] = EXT_COND[EXT_TWO_HIGH_BIT];
            ext_cond_masked[EXT_TWO_LOW_BIT]  = EXT_COND[EXT_TWO_LOW_BIT];
        end
    end

    // reserved positions always read zero
    assign ctl_view  = clk_mon_ff & CLK_MON_MASK;
    assign low_view  = low_ff & LOW_MASK;
    assign high_view = high_ff & HIGH_MASK;
    assign ext_view  = ext_ff & EXT_MASK;

    // per-bit next values, reserved positions stay zero
    genvar gi;
    generate
        for (gi = 0; gi < REG_W; gi++)
        begin : g_low
            assign nxt_low[gi] = LOW_MASK[gi]
                                 ? flag_next(low_ff[gi], LOW_COND[gi], low_clr) : 1'b0;
        end
        for (gi = 0; gi < REG_W; gi++)
        begin : g_high
            assign nxt_high[gi] = HIGH_MASK[gi]
                                  ? flag_next(high_ff[gi], HIGH_COND[gi], high_clr) : 1'b0;
        end
        for (gi = 0; gi < REG_W; gi++)
        begin : g_ext
            assign nxt_ext[gi] = EXT_MASK[gi]
                                 ? flag_next(ext_ff[gi], ext_cond_masked[gi], ext_clr) : 1'b0;
        end
    endgenerate

    // status registers, zero on power-on reset only
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            low_ff <= FLAGS_RESET;
        end
        else
        begin
            low_ff <= nxt_low;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            high_ff <= FLAGS_RESET;
        end
        else
        begin
            high_ff <= nxt_high;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ext_ff <= FLAGS_RESET;
        end
        else
        begin
            ext_ff <= nxt_ext;
        end
    end

    // a write lands only on the unlocked control register outside RESET state
    assign ctrl_wr_hit  = CMD_WR && (cmd_sel == SEL_CLK_MON_ENABLES);
    assign ctrl_wr_take = ctrl_wr_hit && !CTRL_LOCK && !DEVICE_RESET_STATE;

    // next control value: RESET state wins over a write
    always_comb
    begin
        nxt_clk_mon = clk_mon_ff;
        if (DEVICE_RESET_STATE)
        begin
            nxt_clk_mon = CLK_MON_RESET;
        end
        else if (ctrl_wr_take)
        begin
            nxt_clk_mon = CMD_WDATA & CLK_MON_MASK;
        end
    end

    // clock monitor enables
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            clk_mon_ff <= CLK_MON_RESET;
        end
        else
        begin
            clk_mon_ff <= nxt_clk_mon;
        end
    end

    // write answers: one pulse, stored or refused
    always_comb
    begin
        nxt_wr_acc = 1'b0;
        nxt_wr_ref = 1'b0;
        if (CMD_WR)
        begin
            nxt_wr_acc = ctrl_wr_take;
            nxt_wr_ref = !ctrl_wr_take;
        end
    end

    // answer pulses last one cycle each
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wr_acc_ff <= 1'b0;
        end
        else
        begin
            wr_acc_ff <= nxt_wr_acc;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wr_ref_ff <= 1'b0;
        end
        else
        begin
            wr_ref_ff <= nxt_wr_ref;
        end
    end

    // read data captured before the clearing takes effect
    assign rd_mux = sel_read(CMD_SEL, ctl_view, low_view, high_view, ext_view);

    // the answer shows the pre-clear flags; data holds until the next read
    always_comb
    begin
        nxt_rd_valid = CMD_RD;
        nxt_rd_data  = rd_data_ff;
        if (CMD_RD)
        begin
            nxt_rd_data = rd_mux;
        end
    end

    // read strobe answer
    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rd_valid_ff <= 1'b0;
        end
        else
        begin
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            rd_data_ff <= FLAGS_RESET;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign RD_DATA     = rd_data_ff;
    assign RD_VALID    = rd_valid_ff;
    assign WR_ACCEPTED = wr_acc_ff;
    assign WR_REFUSED  = wr_ref_ff;

    // 1 enables a monitor, 0 disables it
    assign BOOST_CLK_CHECK_EN       = clk_mon_ff[BOOST_CLK_CHECK_EN_BIT];
    assign SECOND_BUCK_CLK_CHECK_EN = clk_mon_ff[SECOND_BUCK_CLK_CHECK_EN_BIT];
    assign FIRST_BUCK_CLK_CHECK_EN  = clk_mon_ff[FIRST_BUCK_CLK_CHECK_EN_BIT];
    assign SOURCE_CLK_CHECK_EN      = clk_mon_ff[SOURCE_CLK_CHECK_EN_BIT];
    assign SYNC_INPUT_CLK_CHECK_EN  = clk_mon_ff[SYNC_INPUT_CLK_CHECK_EN_BIT];

    // same latch as the off-state copy of this flag
    assign INPUT_SUPPLY_HIGH_FLAG   = high_ff[INPUT_SUPPLY_HIGH_BIT];

endmodule : scm_regs

// *** test/scm_regs_sva.sv ***
// assertions on the register bank ports
module scm_regs_sva
    import scm_pkg::*;
(
    // clock and reset
    input wire logic             CLK_SYS,
    input wire logic             RSTN,
    // device state, command port and high conditions
    input wire logic             DEVICE_RESET_STATE,
    input wire logic             CTRL_LOCK,
    input wire logic             CMD_RD,
    input wire logic             CMD_WR,
    input wire logic [1:0]       CMD_SEL,
    input wire logic [REG_W-1:0] CMD_WDATA,
    input wire logic [REG_W-1:0] RD_DATA,
    input wire logic             RD_VALID,
    input wire logic             WR_ACCEPTED,
    input wire logic             WR_REFUSED,
    input wire logic [REG_W-1:0] HIGH_COND,
    // enables and mirror
    input wire logic             BOOST_CLK_CHECK_EN,
    input wire logic             SECOND_BUCK_CLK_CHECK_EN,
    input wire logic             FIRST_BUCK_CLK_CHECK_EN,
    input wire logic             SOURCE_CLK_CHECK_EN,
    input wire logic             SYNC_INPUT_CLK_CHECK_EN,
    input wire logic             INPUT_SUPPLY_HIGH_FLAG
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] en;
    assign en = {BOOST_CLK_CHECK_EN, SECOND_BUCK_CLK_CHECK_EN, FIRST_BUCK_CLK_CHECK_EN,
                 SOURCE_CLK_CHECK_EN, SYNC_INPUT_CLK_CHECK_EN};
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence s_open_wr;
        CMD_WR && CMD_SEL == 2'h0 && !CTRL_LOCK && !DEVICE_RESET_STATE;
    endsequence
    sequence s_high_rd;
        CMD_RD && CMD_SEL == 2'h2;
    endsequence
    property p_rd_ans;
        1'b1 |=> RD_VALID == $past(CMD_RD);
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong");
    property p_wr_acc;
        s_open_wr |=> WR_ACCEPTED && en == {$past(CMD_WDATA[6]), $past(CMD_WDATA[4:1])};
    endproperty
    a_wr_acc: assert property (p_wr_acc) else $error("open write lost");
    property p_wr_ref;
        CMD_WR && !DEVICE_RESET_STATE && (CTRL_LOCK || CMD_SEL != 2'h0) |=> WR_REFUSED && $stable(en);
    endproperty
    a_wr_ref: assert property (p_wr_ref) else $error("closed write taken");
    property p_rst_state;
        DEVICE_RESET_STATE |=> en == 5'b11110;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("enables not reloaded");
    property p_ovf_set;
        HIGH_COND[6] |=> INPUT_SUPPLY_HIGH_FLAG;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("flag not set");
    property p_ovf_hold;
        INPUT_SUPPLY_HIGH_FLAG && !(CMD_RD && CMD_SEL == 2'h2) |=> INPUT_SUPPLY_HIGH_FLAG;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("flag not held");
    property p_ovf_clear;
        s_high_rd ##0 !HIGH_COND[6] |=> !INPUT_SUPPLY_HIGH_FLAG && RD_DATA[6] == $past(INPUT_SUPPLY_HIGH_FLAG);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("read clear wrong");
    property p_rd_resv;
        CMD_RD && CMD_SEL == 2'h3 |=> (RD_DATA & ~EXT_MASK) == 8'h00;
    endproperty
    a_rd_resv: assert property (p_rd_resv) else $error("reserved bit set");
endmodule : scm_regs_sva

bind scm_regs scm_regs_sva i_sva (.CLK_SYS, .RSTN, .DEVICE_RESET_STATE, .CTRL_LOCK, .CMD_RD, .CMD_WR,
    .CMD_SEL, .CMD_WDATA, .RD_DATA, .RD_VALID, .WR_ACCEPTED, .WR_REFUSED, .HIGH_COND, .BOOST_CLK_CHECK_EN,
    .SECOND_BUCK_CLK_CHECK_EN, .FIRST_BUCK_CLK_CHECK_EN, .SOURCE_CLK_CHECK_EN, .SYNC_INPUT_CLK_CHECK_EN,
    .INPUT_SUPPLY_HIGH_FLAG);

// *** test/scm_host.sv ***
// controller model driving the register command port
module scm_host
(
    // clock and answers
    input  wire logic       CLK_SYS,
    input  wire logic [7:0] RD_DATA,
    input  wire logic       WR_ACCEPTED,
    // command lines
    output logic            CMD_RD,
    output logic            CMD_WR,
    output logic [1:0]      CMD_SEL,
    output logic [7:0]      CMD_WDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        CMD_RD = 1'b0;
        CMD_WR = 1'b0;
        CMD_SEL = 2'h0;
        CMD_WDATA = 8'h00;
    end
    // idle strobes drop to 0; select and data lines show the inverse of the last value
    task automatic drop;
        CMD_RD = 1'b0;
        CMD_WR = 1'b0;
        CMD_SEL = ~CMD_SEL;
        CMD_WDATA = ~CMD_WDATA;
    endtask : drop
    task automatic rd(input logic [1:0] sel, output logic [7:0] data);
        @(negedge CLK_SYS);
        CMD_RD = 1'b1;
        CMD_SEL = sel;
        @(negedge CLK_SYS);
        data = RD_DATA;
        drop();
    endtask : rd
    task automatic wr(input logic [1:0] sel, input logic [7:0] data, output logic ack);
        @(negedge CLK_SYS);
        CMD_WR = 1'b1;
        CMD_SEL = sel;
        CMD_WDATA = data;
        @(negedge CLK_SYS);
        ack = WR_ACCEPTED;
        drop();
    endtask : wr
endmodule : scm_host

// *** test/scm_regs_tb.sv ***
// self-checking bench for the register bank
module scm_regs_tb
    import scm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       CLK_SYS, RSTN, DEVICE_RESET_STATE, CTRL_LOCK, EXT_ONE_ENABLED, EXT_TWO_ENABLED, ack;
    logic       CMD_RD, CMD_WR, RD_VALID, WR_ACCEPTED, WR_REFUSED, INPUT_SUPPLY_HIGH_FLAG;
    logic       BOOST_CLK_CHECK_EN, SECOND_BUCK_CLK_CHECK_EN, FIRST_BUCK_CLK_CHECK_EN;
    logic       SOURCE_CLK_CHECK_EN, SYNC_INPUT_CLK_CHECK_EN;
    logic [1:0] CMD_SEL;
    logic [7:0] CMD_WDATA, RD_DATA, LOW_COND, HIGH_COND, EXT_COND, got;
    int         err_total = 0;
    int         comparisons = 0;
    scm_regs i_dut (.CLK_SYS, .RSTN, .DEVICE_RESET_STATE, .CTRL_LOCK, .CMD_RD, .CMD_WR, .CMD_SEL, .CMD_WDATA,
        .RD_DATA, .RD_VALID, .WR_ACCEPTED, .WR_REFUSED, .LOW_COND, .HIGH_COND, .EXT_COND, .EXT_ONE_ENABLED,
        .EXT_TWO_ENABLED, .BOOST_CLK_CHECK_EN, .SECOND_BUCK_CLK_CHECK_EN, .FIRST_BUCK_CLK_CHECK_EN,
        .SOURCE_CLK_CHECK_EN, .SYNC_INPUT_CLK_CHECK_EN, .INPUT_SUPPLY_HIGH_FLAG);
    scm_host i_host (.CLK_SYS, .RD_DATA, .WR_ACCEPTED, .CMD_RD, .CMD_WR, .CMD_SEL, .CMD_WDATA);
    initial
    begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic results;
        $display("compares %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    // conditions stay until the next call
    task automatic fault(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] ex);
        @(negedge CLK_SYS);
        LOW_COND = lo;
        HIGH_COND = hi;
        EXT_COND = ex;
        @(negedge CLK_SYS);
    endtask : fault
    initial
    begin
        #(600 * 100);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
    initial
    begin
        RSTN = 1'b0;
        DEVICE_RESET_STATE = 1'b0;
        CTRL_LOCK = 1'b1;
        EXT_ONE_ENABLED = 1'b1;
        EXT_TWO_ENABLED = 1'b0;
        LOW_COND = 8'h00;
        HIGH_COND = 8'h00;
        EXT_COND = 8'h00;
        repeat (20) @(negedge CLK_SYS);
        RSTN = 1'b1;
        i_host.rd(2'h0, got);
        chk(got, 8'h5C);
        chk({7'h00, RD_VALID}, 8'h01);
        chk({3'h0, BOOST_CLK_CHECK_EN, SECOND_BUCK_CLK_CHECK_EN, FIRST_BUCK_CLK_CHECK_EN, SOURCE_CLK_CHECK_EN,
             SYNC_INPUT_CLK_CHECK_EN}, 8'h1E);
        for (int s = 1; s < 4; s++)
        begin
            i_host.rd(2'(s), got);
            chk(got, 8'h00);
        end
        $display("reset values done");
        i_host.wr(2'h0, 8'hFF, ack);
        chk({7'h00, ack}, 8'h00);
        chk({7'h00, WR_REFUSED}, 8'h01);
        CTRL_LOCK = 1'b0;
        i_host.wr(2'h0, 8'hFF, ack);
        chk({7'h00, ack}, 8'h01);
        i_host.rd(2'h0, got);
        chk(got, 8'h5E);
        i_host.wr(2'h1, 8'hFF, ack);
        chk({7'h00, ack}, 8'h00);
        chk({7'h00, WR_REFUSED}, 8'h01);
        i_host.wr(2'h0, 8'h00, ack);
        i_host.rd(2'h0, got);
        chk(got, 8'h00);
        DEVICE_RESET_STATE = 1'b1;
        @(negedge CLK_SYS);
        DEVICE_RESET_STATE = 1'b0;
        i_host.rd(2'h0, got);
        chk(got, 8'h5C);
        $display("control register done");
        fault(8'hFF, 8'hFF, 8'hFF);
        fault(8'h00, 8'h00, 8'h00);
        i_host.rd(2'h1, got);
        chk(got, 8'h5B);
        i_host.rd(2'h1, got);
        chk(got, 8'h00);
        i_host.rd(2'h2, got);
        chk(got, 8'hDB);
        i_host.rd(2'h3, got);
        chk(got, 8'h03);
        EXT_ONE_ENABLED = 1'b0;
        EXT_TWO_ENABLED = 1'b1;
        fault(8'h00, 8'h00, 8'hFF);
        fault(8'h00, 8'h00, 8'h00);
        i_host.rd(2'h3, got);
        chk(got, 8'h30);
        $display("status flags done");
        fault(8'h01, 8'h40, 8'h00);
        i_host.rd(2'h1, got);
        chk(got, 8'h01);
        i_host.rd(2'h2, got);
        chk(got, 8'h40);
        i_host.rd(2'h1, got);
        chk(got, 8'h01);
        fault(8'h00, 8'h00, 8'h00);
        i_host.rd(2'h2, got);
        chk(got, 8'h40);
        i_host.rd(2'h1, got);
        chk(got, 8'h01);
        i_host.rd(2'h1, got);
        chk(got, 8'h00);
        $display("persistent fault done");
        results();
    end
endmodule : scm_regs_tb
